// ==== pkg/bcr_pkg.sv ====
// bcr_pkg: constants and types for the bus control configuration register
// Notes on behaviour
// R1: 16-bit register, zero at power-on, else kept
// R2: software initialises it before other-area accesses
// R3: address pull-up four cycles after bus acknowledge
// R4: data pull-up while data bus idle
// R5: standby memory pins float or drive high
// R6: strobes float or driven in standby/release
// R7: read-only byte-order flag latched at power-on
// R8: area 0 burst field selects burst length
// R9: bits 8..7 select area 5 burst
// R10: area 5 burst codes 4, 8, 16
// R11: area 6 burst field same encoding
// R12: bits 4..2 select area 2/3 memory types
// R13: bits 1, 0 select card space
// R14: byte-order flag ignores writes, rest read back
`default_nettype none
package bcr_pkg;
	// register byte address on the apb bus
	localparam logic [11:0] BCR_ADDR_BUS_CONTROL_ONE = 12'h000;
	localparam logic [15:0] BCR_RESET_VALUE = 16'h0000;
	// field positions
	localparam int BCR_BIT_ADDR_PULLUP = 15;
	localparam int BCR_BIT_DATA_PULLUP = 14;
	localparam int BCR_BIT_MEM_DRIVE = 13;
	localparam int BCR_BIT_STROBE_DRIVE = 12;
	localparam int BCR_BIT_BYTE_ORDER = 11;
	localparam int BCR_BIT_AREA0_BURST = 9;
	localparam int BCR_BIT_AREA5_BURST = 7;
	localparam int BCR_BIT_AREA6_BURST = 5;
	localparam int BCR_BIT_MEMTYPE = 2;
	localparam int BCR_BIT_AREA5_CARD = 1;
	localparam int BCR_BIT_AREA6_CARD = 0;
	// writable bits: all but the byte-order flag
	localparam logic [15:0] BCR_WRITE_MASK = 16'hf7ff;
	// address pull-up hold after bus acknowledge
	localparam logic [2:0] BCR_PULLUP_CYCLES = 3'h4;
	// burst field codes
	localparam logic [1:0] BCR_BURST_NONE = 2'h0;
	localparam logic [1:0] BCR_BURST_4 = 2'h1;
	localparam logic [1:0] BCR_BURST_8 = 2'h2;
	localparam logic [1:0] BCR_BURST_16 = 2'h3;
	localparam logic [4:0] BCR_BEATS_1 = 5'h01;
	localparam logic [4:0] BCR_BEATS_4 = 5'h04;
	localparam logic [4:0] BCR_BEATS_8 = 5'h08;
	localparam logic [4:0] BCR_BEATS_16 = 5'h10;
	// bus width codes of an area
	localparam logic [1:0] BCR_WIDTH_8 = 2'h1;
	localparam logic [1:0] BCR_WIDTH_16 = 2'h2;
	localparam logic [1:0] BCR_WIDTH_32 = 2'h3;
	// area 2/3 memory type codes
	localparam logic [2:0] BCR_MT_ORDINARY = 3'h0;
	localparam logic [2:0] BCR_MT_A3_SDRAM = 3'h2;
	localparam logic [2:0] BCR_MT_BOTH_SDRAM = 3'h3;
	localparam logic [2:0] BCR_MT_A3_DRAM = 3'h4;
	localparam logic [2:0] BCR_MT_BOTH_DRAM = 3'h5;
	// memory kind of one area
	typedef enum logic [2:0] {
		BCR_MEM_ORDINARY = 3'b001,
		BCR_MEM_SDRAM = 3'b010,
		BCR_MEM_DRAM = 3'b100
	} bcr_mem_e;
	// decoded burst setting of one area
	typedef struct packed {
		logic burst_en;
		logic [4:0] beats;
		logic width_ok;
	} bcr_burst_s;
	// pin control outputs
	typedef struct packed {
		logic addr_pullup;
		logic data_pullup;
		logic mem_pins_oe;
		logic mem_pins_high;
		logic strobe_oe;
	} bcr_pins_s;
	// decoded area configuration
	typedef struct packed {
		bcr_burst_s area0;
		bcr_burst_s area5;
		bcr_burst_s area6;
		bcr_mem_e area2_mem;
		bcr_mem_e area3_mem;
		logic memtype_reserved;
		logic area5_card_space;
		logic area6_card_space;
		logic big_endian;
	} bcr_cfg_s;
endpackage
`default_nettype wire

// ==== rtl/bcr_burst_dec.sv ====
// bcr_burst_dec: decodes one two-bit burst field against bus width
`timescale 1ns/100ps
`default_nettype none
module bcr_burst_dec
(
	// field and width of the area
	input wire logic [1:0] field,
	input wire logic [1:0] width,
	// decoded setting
	output var bcr_pkg::bcr_burst_s burst
);
	import bcr_pkg::*;

	// code to beat count and width check
	always_comb
	begin
		burst.burst_en = (field != BCR_BURST_NONE);
		case (field)
			BCR_BURST_4:
			begin
				burst.beats = BCR_BEATS_4;
				burst.width_ok = 1'b1;
			end
			BCR_BURST_8:
			begin
				// only 8 or 16 bit buses
				burst.beats = BCR_BEATS_8;
				burst.width_ok = (width != BCR_WIDTH_32);
			end
			BCR_BURST_16:
			begin
				// 8 bit bus only
				burst.beats = BCR_BEATS_16;
				burst.width_ok = (width == BCR_WIDTH_8);
			end
			default:
			begin
				burst.beats = BCR_BEATS_1;
				burst.width_ok = 1'b1;
			end
		endcase
	end
endmodule // bcr_burst_dec
`default_nettype wire

// ==== rtl/bcr_bus_control_one.sv ====
// bcr_bus_control_one: apb register holding bus control configuration
//
// Chosen here: the register offsets and the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module bcr_bus_control_one
(
	// apb clock and power-on reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// byte-order strap, sampled after power-on reset
	input wire logic byte_order_mode_pin,
	// bus state inputs
	input wire logic bus_ack,
	input wire logic data_bus_idle,
	input wire logic standby,
	// bus widths of areas 0, 5, 6
	input wire logic [1:0] area0_width,
	input wire logic [1:0] area5_width,
	input wire logic [1:0] area6_width,
	// pin control and decoded configuration
	output var bcr_pkg::bcr_pins_s pins,
	output var bcr_pkg::bcr_cfg_s cfg,
	output logic [15:0] bus_control_one
);
	import bcr_pkg::*;

	// whole module state
	typedef struct packed {
		logic [15:0] bus_control_one;
		logic strap_done;
		logic [2:0] pullup_cnt;
		logic bus_ack_d;
		logic [31:0] rdata;
		logic slverr;
		bcr_pins_s pins;
	} bcr_state_s;

	bcr_state_s st_reg;
	bcr_state_s st_next;
	logic hit;
	logic wr_en;
	logic rd_en;
	bcr_burst_s burst0;
	bcr_burst_s burst5;
	bcr_burst_s burst6;
	logic [2:0] memtype;
	logic released;

	// address decode; only one register word is mapped
	always_comb
	begin
		if (paddr == BCR_ADDR_BUS_CONTROL_ONE)
		begin
			hit = 1'b1;
		end
		else
		begin
			hit = 1'b0;
		end
	end

	// zero wait state: accesses complete in their setup-to-access cycle
	assign wr_en = psel && penable && pwrite && hit;
	assign rd_en = psel && !penable && !pwrite;
	assign released = standby || bus_ack;

	// next-state logic
	always_comb
	begin
		st_next = st_reg;
		// R7: catch strap once after reset release
		if (!st_reg.strap_done)
		begin
			st_next.strap_done = 1'b1;
			st_next.bus_control_one[BCR_BIT_BYTE_ORDER] = byte_order_mode_pin;
		end
		// R14: flag bit masked off on writes
		if (wr_en)
		begin
			st_next.bus_control_one = (pwdata[15:0] & BCR_WRITE_MASK)
				| (st_next.bus_control_one & ~BCR_WRITE_MASK);
		end
		// read data prepared in setup cycle, upper bits zero
		if (rd_en)
		begin
			st_next.rdata = hit ? {16'h0000, st_next.bus_control_one}
				: 32'h0000_0000;
		end
		// unmapped address answers with an error
		st_next.slverr = psel && !penable && !hit;
		// R3: count four cycles from the rise of bus acknowledge
		st_next.bus_ack_d = bus_ack;
		if (bus_ack && !st_reg.bus_ack_d)
		begin
			st_next.pullup_cnt = BCR_PULLUP_CYCLES;
		end
		else if (st_reg.pullup_cnt != 3'h0)
		begin
			st_next.pullup_cnt = st_reg.pullup_cnt - 3'h1;
		end
		// R3: pull-up only while enabled and counting
		st_next.pins.addr_pullup = st_reg.bus_control_one[BCR_BIT_ADDR_PULLUP]
			&& (st_next.pullup_cnt != 3'h0);
		// R4: data pull-up while idle
		st_next.pins.data_pullup = st_reg.bus_control_one[BCR_BIT_DATA_PULLUP]
			&& data_bus_idle;
		// R5: standby float or drive high
		st_next.pins.mem_pins_oe = !standby
			|| st_reg.bus_control_one[BCR_BIT_MEM_DRIVE];
		st_next.pins.mem_pins_high = standby
			&& st_reg.bus_control_one[BCR_BIT_MEM_DRIVE];
		// R6: strobes float unless kept driven
		st_next.pins.strobe_oe = !released
			|| st_reg.bus_control_one[BCR_BIT_STROBE_DRIVE];
	end

	// R1: only power-on reset clears; no other reset input exists
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			st_reg <= '0;
			st_reg.bus_control_one <= BCR_RESET_VALUE;
			st_reg.pins.mem_pins_oe <= 1'b1;
			st_reg.pins.strobe_oe <= 1'b1;
		end
		else
		begin
			st_reg <= st_next;
		end
	end

	// R8: area 0 burst decode
	bcr_burst_dec u_area0
	(
		.field(st_reg.bus_control_one[BCR_BIT_AREA0_BURST +: 2]),
		.width(area0_width),
		.burst(burst0)
	);
	// R9: area 5 burst decode, R10 codes
	bcr_burst_dec u_area5
	(
		.field(st_reg.bus_control_one[BCR_BIT_AREA5_BURST +: 2]),
		.width(area5_width),
		.burst(burst5)
	);
	// R11: area 6 uses same decode
	bcr_burst_dec u_area6
	(
		.field(st_reg.bus_control_one[BCR_BIT_AREA6_BURST +: 2]),
		.width(area6_width),
		.burst(burst6)
	);

	assign memtype = st_reg.bus_control_one[BCR_BIT_MEMTYPE +: 3];

	// decoded configuration for the bus cycle logic
	always_comb
	begin
		cfg.area0 = burst0;
		cfg.area5 = burst5;
		cfg.area6 = burst6;
		cfg.area2_mem = BCR_MEM_ORDINARY;
		cfg.area3_mem = BCR_MEM_ORDINARY;
		cfg.memtype_reserved = 1'b0;
		// R12: area 2/3 memory types
		case (memtype)
			BCR_MT_ORDINARY:
			begin
				cfg.memtype_reserved = 1'b0;
			end
			BCR_MT_A3_SDRAM:
			begin
				cfg.area3_mem = BCR_MEM_SDRAM;
			end
			BCR_MT_BOTH_SDRAM:
			begin
				cfg.area2_mem = BCR_MEM_SDRAM;
				cfg.area3_mem = BCR_MEM_SDRAM;
			end
			BCR_MT_A3_DRAM:
			begin
				cfg.area3_mem = BCR_MEM_DRAM;
			end
			BCR_MT_BOTH_DRAM:
			begin
				cfg.area2_mem = BCR_MEM_DRAM;
				cfg.area3_mem = BCR_MEM_DRAM;
			end
			default:
			begin
				// reserved codes fall back to ordinary memory
				cfg.memtype_reserved = 1'b1;
			end
		endcase
		// R13: card space selection
		cfg.area5_card_space = st_reg.bus_control_one[BCR_BIT_AREA5_CARD];
		cfg.area6_card_space = st_reg.bus_control_one[BCR_BIT_AREA6_CARD];
		// R7: flag, inverted, decides byte order at cfg.big_endian only
		cfg.big_endian = !st_reg.bus_control_one[BCR_BIT_BYTE_ORDER];
	end

	// apb answers
	assign pready = 1'b1;
	assign prdata = st_reg.rdata;
	assign pslverr = st_reg.slverr && psel && penable;
	assign pins = st_reg.pins;
	assign bus_control_one = st_reg.bus_control_one;
endmodule // bcr_bus_control_one
`default_nettype wire

// ==== verification/bcr_checker.sv ====
// bcr_checker: concurrent checks on the register block ports
`timescale 1ns/100ps
`default_nettype none
module bcr_checker
(
	// clock, reset, apb
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// bus state
	input wire logic bus_ack,
	input wire logic data_bus_idle,
	input wire logic standby,
	// watched outputs
	input wire bcr_pkg::bcr_pins_s pins,
	input wire bcr_pkg::bcr_cfg_s cfg,
	input wire logic [15:0] bus_control_one
);
	import bcr_pkg::*;

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// short aliases
	wire [15:0] r = bus_control_one;
	wire [15:0] pw = pwdata[15:0];
	wire hit = paddr == BCR_ADDR_BUS_CONTROL_ONE;
	// acknowledge rising with pull-up on
	sequence s_ack_rise;
		$rose(bus_ack) && r[15];
	endsequence
	// pull-up follows the enable bit for four cycles
	sequence s_pull4;
		(pins.addr_pullup == $past(r[15])) [*4];
	endsequence
	// no new acknowledge rise for four cycles
	sequence s_quiet4;
		(!$rose(bus_ack)) [*4];
	endsequence
	a_addr_pull_four: assert property (s_ack_rise |=> s_pull4)
		else $error("address pull-up not held");
	a_pull_ends: assert property ($rose(bus_ack) ##1 s_quiet4 |=>
		!pins.addr_pullup)
		else $error("address pull-up held too long");
	a_data_pull: assert property ($stable({data_bus_idle, r[14]}) |->
		pins.data_pullup == (data_bus_idle && r[14]))
		else $error("data pull-up wrong");
	a_mem_pin_state: assert property ($stable({standby, r[13]}) |->
		pins.mem_pins_oe == (!standby || r[13]) &&
		pins.mem_pins_high == (standby && r[13]))
		else $error("standby pin state wrong");
	a_strobe_drive: assert property ($stable({standby, bus_ack, r[12]}) |->
		pins.strobe_oe == (!(standby || bus_ack) || r[12]))
		else $error("strobe drive wrong");
	a_flag_read_only: assert property ($past(presetn, 2) |->
		$stable(r[11]))
		else $error("byte-order flag changed");
	a_write_merge: assert property (psel && penable && pwrite && hit |=>
		r == (($past(pw) & BCR_WRITE_MASK) | ($past(r) & ~BCR_WRITE_MASK)))
		else $error("register write wrong");
	a_read_word: assert property (psel && !penable && !pwrite && hit |=>
		prdata == {16'h0000, r} && pready)
		else $error("read data wrong");
	a_unmapped_err: assert property (psel && penable |->
		pslverr == !hit)
		else $error("slave error wrong");
	a_card_endian: assert property (cfg.area5_card_space == r[1] &&
		cfg.area6_card_space == r[0] && cfg.big_endian == !r[11])
		else $error("card space or byte order wrong");
endmodule // bcr_checker
bind bcr_bus_control_one bcr_checker u_chk (.pclk(pclk),
	.presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .bus_ack(bus_ack), .data_bus_idle(data_bus_idle),
	.standby(standby), .pins(pins), .cfg(cfg),
	.bus_control_one(bus_control_one));
`default_nettype wire

// ==== verification/bcr_bus_peer.sv ====
// bcr_bus_peer: far-side bus activity, random or quiet
`timescale 1ns/100ps
`default_nettype none
module bcr_bus_peer (
	// clock and bench controls
	input wire logic pclk,
	input wire logic busy_en,
	input wire logic ack_req,
	// bus state seen by the block
	output logic bus_ack,
	output logic data_bus_idle,
	output logic standby
);
	// ack, idle, standby; idle bus when quiet
	logic [2:0] rnd_reg = 3'h2;
	always @(posedge pclk)
		rnd_reg <= busy_en ? 3'($urandom) : 3'h2;
	assign bus_ack = rnd_reg[0] | ack_req;
	assign data_bus_idle = rnd_reg[1];
	assign standby = rnd_reg[2];
endmodule // bcr_bus_peer
`default_nettype wire

// ==== verification/bus_control_config_register_tb.sv ====
// bus_control_config_register_tb: self-checking register bench
`timescale 1ns/100ps
`default_nettype none
module bus_control_config_register_tb;
	import bcr_pkg::*;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata;
	logic pready, pslverr, byte_order_mode_pin = 1;
	logic busy_en = 0, ack_req = 0, bus_ack, data_bus_idle, standby;
	logic [1:0] area0_width = 2'h1, area5_width = 2'h2, area6_width = 2'h3;
	bcr_pins_s pins;
	bcr_cfg_s cfg;
	logic [15:0] bus_control_one, rd, exp, v;
	int n_fail = 0, num_checks = 0, k, cnt;
	localparam logic [11:0] A = BCR_ADDR_BUS_CONTROL_ONE;
	// 100 MHz clock
	always #5 pclk = ~pclk;
	bcr_bus_control_one uut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.byte_order_mode_pin(byte_order_mode_pin), .bus_ack(bus_ack),
		.data_bus_idle(data_bus_idle), .standby(standby),
		.area0_width(area0_width), .area5_width(area5_width),
		.area6_width(area6_width), .pins(pins), .cfg(cfg),
		.bus_control_one(bus_control_one));
	bcr_bus_peer peer (.pclk(pclk), .busy_en(busy_en), .ack_req(ack_req),
		.bus_ack(bus_ack), .data_bus_idle(data_bus_idle), .standby(standby));
	// expected {enable, beats, width ok} of a burst code on a bus width
	function automatic logic [6:0] bst(input logic [1:0] c, w);
		logic [4:0] b;
		logic ok;
		b = (c == BCR_BURST_NONE) ? BCR_BEATS_1 : 5'(5'h02 << c);
		ok = (c == BCR_BURST_16) ? (w == BCR_WIDTH_8)
			: (c == BCR_BURST_8) ? (w != BCR_WIDTH_32) : 1'b1;
		return {c != BCR_BURST_NONE, b, ok};
	endfunction
	// expected reserved flag, kinds of area 2 then area 3
	function automatic logic [6:0] mt(input logic [2:0] c);
		case (c)
			3'h0: return 7'b0001001;
			3'h2: return 7'b0001010;
			3'h3: return 7'b0010010;
			3'h4: return 7'b0001100;
			3'h5: return 7'b0100100;
			default: return 7'b1001001;
		endcase
	endfunction
	// one apb transfer, idle cycle first so signals never clash
	task automatic apb(input logic wr, input logic [11:0] a,
		input logic [15:0] d, output logic [15:0] q);
		@(posedge pclk);
		psel <= 1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= {16'h0000, d};
		@(posedge pclk);
		penable <= 1;
		for (k = 0; k < 16; k++)
		begin
			@(posedge pclk);
			if (pready === 1'b1)
				break;
		end
		if (k == 16)
		begin
			n_fail++;
			tally_and_finish();
		end
		q = prdata[15:0];
		psel <= 0;
		penable <= 0;
	endtask
	// compare one value
	task automatic chk(input string nm, input logic [15:0] e, g);
		num_checks++;
		if (g !== e)
		begin
			n_fail++;
			$display("[ERR] %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// main sequence
	initial
	begin
		void'($urandom(32'h7ffd));
		repeat (8) @(posedge pclk);
		presetn <= 1;
		apb(0, A, 0, rd);
		chk("reset", 16'h0800, rd);
		$display("test reset done");
		// every code of each field, random rest
		for (int i = 0; i < 24; i++)
		begin
			v = 16'($urandom);
			v[10:5] = {3{i[1:0]}};
			v[4:2] = i[2:0];
			apb(1, A, v, rd);
			busy_en <= 1;
			area0_width <= 2'($urandom_range(1, 3));
			area5_width <= 2'($urandom_range(1, 3));
			area6_width <= 2'($urandom_range(1, 3));
			exp = (v & 16'hf7ff) | 16'h0800;
			apb(0, A, 0, rd);
			chk("readback", exp, rd);
			chk("area0", 16'(bst(v[10:9], area0_width)), 16'(cfg.area0));
			chk("area5", 16'(bst(v[8:7], area5_width)), 16'(cfg.area5));
			chk("area6", 16'(bst(v[6:5], area6_width)), 16'(cfg.area6));
			chk("memtype", 16'(mt(v[4:2])),
				16'({cfg.memtype_reserved, cfg.area2_mem, cfg.area3_mem}));
		end
		$display("test fields done");
		apb(1, 12'h004, 16'hffff, rd);
		apb(0, 12'h004, 0, rd);
		chk("unmapped", 16'h0000, rd);
		apb(0, A, 0, rd);
		chk("kept", exp, rd);
		$display("test unmapped done");
		busy_en <= 0;
		apb(1, A, 16'h8000, rd);
		// let a pull-up count left from random acknowledges run out
		repeat (6) @(posedge pclk);
		ack_req <= 1;
		cnt = 0;
		repeat (10) @(posedge pclk)
			if (pins.addr_pullup === 1'b1)
				cnt++;
		ack_req <= 0;
		chk("pullup", 16'h0004, 16'(cnt));
		$display("test pullup done");
		byte_order_mode_pin <= 0;
		presetn <= 0;
		repeat (3) @(posedge pclk);
		presetn <= 1;
		apb(0, A, 0, rd);
		chk("rereset", 16'h0000, rd);
		$display("test rereset done");
		tally_and_finish();
	end
endmodule // bus_control_config_register_tb
`default_nettype wire
